// ==== hdl/adc_command_set.sv ====
// Command interpreter for the sound controller command/data port
`timescale 1ns/1ps
module adc_command_set (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [1:0] busAddr,
  input wire logic [7:0] busWrData,
  input wire logic busWrite,
  input wire logic busRead,
  output logic [7:0] busRdData,
  // DMA engine side
  input wire logic dmaDone,
  output adc_pkg::adc_xfer_type xferReq,
  // Status
  output adc_pkg::adc_stat_type statOut
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    adc_pkg::adc_state_type st;
    logic [7:0] op;
    logic [7:0] lowByte;
    logic [15:0] blockSize;
    logic [7:0] rdData;
    logic rdValid;
    logic [7:0] busRd;
    logic dmaActive;
    adc_pkg::adc_xfer_type xfer;
    adc_pkg::adc_stat_type stat;
  } adc_regs_type;

  adc_regs_type r_q;
  adc_regs_type r_d;

  // Data bytes a command needs: 0, 1 or 2
  function automatic logic [1:0] dataBytes(input logic [7:0] op);
    logic [1:0] n;
    n = 2'h0;
    case (op)
      adc_pkg::OP_BLKSIZE, adc_pkg::OP_CMP_LO, adc_pkg::OP_CMP_LOR,
      adc_pkg::OP_CMP_MD, adc_pkg::OP_CMP_MDR, adc_pkg::OP_CMP_HI,
      adc_pkg::OP_CMP_HIR, adc_pkg::OP_CMP_REC, adc_pkg::OP_CMP_RECR,
      adc_pkg::OP_AD4, adc_pkg::OP_AD4R, adc_pkg::OP_AD26,
      adc_pkg::OP_AD26R, adc_pkg::OP_AD2, adc_pkg::OP_AD2R,
      adc_pkg::OP_SILENCE: n = 2'h2;
      adc_pkg::OP_GPO_WR, adc_pkg::OP_GAIN_WR,
      adc_pkg::OP_LEG_WR: n = 2'h1;
      default: n = 2'h0;
    endcase
    return n;
  endfunction : dataBytes

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [15:0] word;
    logic exec;
    logic [7:0] cmd;
    word = 16'h0000;
    exec = 1'b0;
    cmd = 8'h00;
    r_d = r_q;
    r_d.xfer.start = 1'b0;
    r_d.stat.resumeReq = 1'b0;
    r_d.busRd = 8'h00;
    if (dmaDone) begin
      r_d.dmaActive = 1'b0;
      r_d.stat.dmaPaused = 1'b0;
    end
    if (busRead) begin
      if (busAddr == adc_pkg::ADDR_CMD) begin
        r_d.busRd = r_q.rdData;
        r_d.rdValid = 1'b0;
      end else if (busAddr == adc_pkg::ADDR_STAT) begin
        r_d.busRd = {r_q.rdValid, 5'h00, r_q.st};
      end else if (busAddr == adc_pkg::ADDR_DMA) begin
        r_d.busRd = {r_q.xfer.mode, r_q.xfer.refByte, r_q.xfer.record,
                     r_q.dmaActive, r_q.stat.dmaPaused};
      end else begin
        r_d.busRd = {4'h0, r_q.stat.inputGain};
      end
    end
    if (busWrite && busAddr == adc_pkg::ADDR_CMD) begin
      case (r_q.st)
        adc_pkg::ST_IDLE: begin
          r_d.op = busWrData;
          if (dataBytes(busWrData) == 2'h0) begin
            exec = 1'b1;
            cmd = busWrData;
          end else begin
            r_d.st = adc_pkg::ST_LOW;
          end
        end
        adc_pkg::ST_LOW: begin
          r_d.lowByte = busWrData;
          if (dataBytes(r_q.op) == 2'h1) begin
            exec = 1'b1;
            cmd = r_q.op;
            word = {8'h00, busWrData};
            r_d.st = adc_pkg::ST_IDLE;
          end else begin
            r_d.st = adc_pkg::ST_HIGH;
          end
        end
        default: begin
          exec = 1'b1;
          cmd = r_q.op;
          word = {busWrData, r_q.lowByte};
          r_d.st = adc_pkg::ST_IDLE;
        end
      endcase
    end
    if (exec) begin
      // Odd opcodes of the pair carry the reference byte flag
      if (cmd[7:4] == 4'h6 || cmd[7:4] == 4'h7) begin
        r_d.xfer.start = 1'b1;
        r_d.xfer.refByte = cmd[0];
        r_d.xfer.record = 1'b0;
        r_d.xfer.autoInit = 1'b0;
        r_d.xfer.count = word;
        r_d.dmaActive = 1'b1;
        r_d.stat.dmaPaused = 1'b0;
        case ({cmd[7:1], 1'b0})
          adc_pkg::OP_CMP_LO: r_d.xfer.mode = adc_pkg::MODE_CMP_LO;
          adc_pkg::OP_CMP_MD: r_d.xfer.mode = adc_pkg::MODE_CMP_MD;
          adc_pkg::OP_CMP_HI: r_d.xfer.mode = adc_pkg::MODE_CMP_HI;
          adc_pkg::OP_CMP_REC: begin
            r_d.xfer.mode = adc_pkg::MODE_CMP_REC;
            r_d.xfer.record = 1'b1;
          end
          adc_pkg::OP_AD4: r_d.xfer.mode = adc_pkg::MODE_AD4;
          adc_pkg::OP_AD26: r_d.xfer.mode = adc_pkg::MODE_AD26;
          adc_pkg::OP_AD2: r_d.xfer.mode = adc_pkg::MODE_AD2;
          default: begin
            // Unknown codes in this range leave the last request intact
            r_d.xfer = r_q.xfer;
            r_d.xfer.start = 1'b0;
            r_d.dmaActive = r_q.dmaActive;
            r_d.stat.dmaPaused = r_q.stat.dmaPaused;
          end
        endcase
      end
      case (cmd)
        adc_pkg::OP_BLKSIZE: r_d.blockSize = word;
        adc_pkg::OP_SILENCE: begin
          r_d.xfer.start = 1'b1;
          r_d.xfer.mode = adc_pkg::MODE_SILENCE;
          r_d.xfer.refByte = 1'b0;
          r_d.xfer.record = 1'b0;
          r_d.xfer.autoInit = 1'b0;
          r_d.xfer.count = word;
        end
        adc_pkg::OP_AUTO8, adc_pkg::OP_SING8,
        adc_pkg::OP_HSREC_A, adc_pkg::OP_HSREC_S: begin
          r_d.xfer.start = 1'b1;
          r_d.xfer.refByte = 1'b0;
          r_d.xfer.count = r_q.blockSize;
          r_d.xfer.autoInit = ~cmd[0];
          r_d.xfer.record = cmd[3];
          r_d.dmaActive = 1'b1;
          r_d.stat.dmaPaused = 1'b0;
          case (cmd)
            adc_pkg::OP_AUTO8: r_d.xfer.mode = adc_pkg::MODE_AUTO8;
            adc_pkg::OP_SING8: r_d.xfer.mode = adc_pkg::MODE_SING8;
            adc_pkg::OP_HSREC_A: r_d.xfer.mode = adc_pkg::MODE_HSREC_A;
            default: r_d.xfer.mode = adc_pkg::MODE_HSREC_S;
          endcase
        end
        adc_pkg::OP_RESUME: r_d.stat.resumeReq = 1'b1;
        adc_pkg::OP_EXT_ON: r_d.stat.extEnable = 1'b1;
        adc_pkg::OP_EXT_OFF: r_d.stat.extEnable = 1'b0;
        adc_pkg::OP_GPO_RD: begin
          r_d.rdData = r_q.stat.gpoReg;
          r_d.rdValid = 1'b1;
        end
        adc_pkg::OP_GPO_WR: r_d.stat.gpoReg = word[7:0];
        adc_pkg::OP_PAUSE: begin
          if (r_q.dmaActive) begin
            r_d.stat.dmaPaused = 1'b1;
          end
        end
        adc_pkg::OP_CONT: r_d.stat.dmaPaused = 1'b0;
        adc_pkg::OP_VOICE_ON: r_d.stat.voiceEnable = 1'b1;
        adc_pkg::OP_VOICE_OFF: r_d.stat.voiceEnable = 1'b0;
        adc_pkg::OP_VOICE_ST: begin
          r_d.rdData = r_q.stat.voiceEnable ? adc_pkg::ALL_ONES
                                            : 8'h00;
          r_d.rdValid = 1'b1;
        end
        adc_pkg::OP_ONE: begin
          r_d.rdData = adc_pkg::READ_ONE;
          r_d.rdValid = 1'b1;
        end
        // Unsupported legacy pair: no read byte, write byte dropped
        adc_pkg::OP_LEG_RD, adc_pkg::OP_LEG_WR: r_d.op = r_q.op;
        adc_pkg::OP_GAIN_RD: begin
          r_d.rdData = {4'h0, r_q.stat.inputGain};
          r_d.rdValid = 1'b1;
        end
        adc_pkg::OP_GAIN_WR: r_d.stat.inputGain = word[3:0];
        default: r_d.op = r_d.op;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      r_q <= '0;
      r_q.st <= adc_pkg::ST_IDLE;
      r_q.blockSize <= adc_pkg::COUNT_RESET;
      r_q.stat.extEnable <= 1'b0;
      r_q.stat.gpoReg <= adc_pkg::GPO_RESET;
      r_q.stat.inputGain <= adc_pkg::GAIN_RESET;
      r_q.xfer.mode <= adc_pkg::MODE_NONE;
    end else begin
      r_q <= r_d;
    end
  end

  assign busRdData = r_q.busRd;
  assign xferReq = r_q.xfer;
  assign statOut = r_q.stat;
endmodule : adc_command_set

// ==== hdl/adc_pkg.sv ====
// Package for the sound command interpreter: opcodes, states, carriers
package adc_pkg;
  // ****************************************
  // Port map
  // ****************************************
  localparam logic [1:0] ADDR_CMD = 2'h0;
  localparam logic [1:0] ADDR_STAT = 2'h1;
  localparam logic [1:0] ADDR_DMA = 2'h2;
  localparam logic [1:0] ADDR_CTRL = 2'h3;
  localparam logic [7:0] READ_ONE = 8'h01;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] GPO_RESET = 8'h00;
  localparam logic [3:0] GAIN_RESET = 4'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_BLKSIZE = 8'h48;
  localparam logic [7:0] OP_CMP_LO = 8'h64;
  localparam logic [7:0] OP_CMP_LOR = 8'h65;
  localparam logic [7:0] OP_CMP_MD = 8'h66;
  localparam logic [7:0] OP_CMP_MDR = 8'h67;
  localparam logic [7:0] OP_CMP_HI = 8'h6a;
  localparam logic [7:0] OP_CMP_HIR = 8'h6b;
  localparam logic [7:0] OP_CMP_REC = 8'h6e;
  localparam logic [7:0] OP_CMP_RECR = 8'h6f;
  localparam logic [7:0] OP_AD4 = 8'h74;
  localparam logic [7:0] OP_AD4R = 8'h75;
  localparam logic [7:0] OP_AD26 = 8'h76;
  localparam logic [7:0] OP_AD26R = 8'h77;
  localparam logic [7:0] OP_AD2 = 8'h7a;
  localparam logic [7:0] OP_AD2R = 8'h7b;
  localparam logic [7:0] OP_SILENCE = 8'h80;
  localparam logic [7:0] OP_AUTO8 = 8'h90;
  localparam logic [7:0] OP_SING8 = 8'h91;
  localparam logic [7:0] OP_HSREC_A = 8'h98;
  localparam logic [7:0] OP_HSREC_S = 8'h99;
  localparam logic [7:0] OP_RESUME = 8'hc1;
  localparam logic [7:0] OP_EXT_ON = 8'hc6;
  localparam logic [7:0] OP_EXT_OFF = 8'hc7;
  localparam logic [7:0] OP_GPO_RD = 8'hce;
  localparam logic [7:0] OP_GPO_WR = 8'hcf;
  localparam logic [7:0] OP_PAUSE = 8'hd0;
  localparam logic [7:0] OP_VOICE_ON = 8'hd1;
  localparam logic [7:0] OP_VOICE_OFF = 8'hd3;
  localparam logic [7:0] OP_CONT = 8'hd4;
  localparam logic [7:0] OP_ONE = 8'hd5;
  localparam logic [7:0] OP_LEG_RD = 8'hd6;
  localparam logic [7:0] OP_LEG_WR = 8'hd7;
  localparam logic [7:0] OP_VOICE_ST = 8'hd8;
  localparam logic [7:0] OP_GAIN_RD = 8'hdc;
  localparam logic [7:0] OP_GAIN_WR = 8'hdd;
  // ****************************************
  // Transfer modes
  // ****************************************
  typedef enum logic [3:0] {
    MODE_NONE = 4'h0, MODE_CMP_LO = 4'h1, MODE_CMP_MD = 4'h2,
    MODE_CMP_HI = 4'h3, MODE_CMP_REC = 4'h4, MODE_AD4 = 4'h5,
    MODE_AD26 = 4'h6, MODE_AD2 = 4'h7, MODE_SILENCE = 4'h8,
    MODE_AUTO8 = 4'h9, MODE_SING8 = 4'ha, MODE_HSREC_A = 4'hb,
    MODE_HSREC_S = 4'hc
  } adc_mode_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_LOW = 2'b01, ST_HIGH = 2'b11
  } adc_state_type;
  // Start request handed to the DMA engine
  typedef struct packed {
    logic start;
    adc_mode_type mode;
    logic refByte;
    logic record;
    logic autoInit;
    logic [15:0] count;
  } adc_xfer_type;
  // Status outputs
  typedef struct packed {
    logic extEnable;
    logic voiceEnable;
    logic dmaPaused;
    logic resumeReq;
    logic [3:0] inputGain;
    logic [7:0] gpoReg;
  } adc_stat_type;
endpackage : adc_pkg

// ==== dv/adc_command_set_props.sv ====
// Port checker for the command interpreter
`timescale 1ns/1ps
module adc_command_set_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [1:0] busAddr,
  input wire logic [7:0] busWrData,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic [7:0] busRdData,
  // DMA and status
  input wire logic dmaDone,
  input wire adc_pkg::adc_xfer_type xferReq,
  input wire adc_pkg::adc_stat_type statOut
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic cmdWr;
  assign cmdWr = busWrite && busAddr == adc_pkg::ADDR_CMD;
  AST_RD_ZERO: assert property (!$past(busRead) |-> busRdData == 8'h00)
    else $error("read data outside reply cycle");
  AST_START_CAUSE: assert property (xferReq.start |-> $past(cmdWr))
    else $error("start without a final byte");
  AST_VOICE_ON: assert property ($rose(statOut.voiceEnable) |->
    $past(cmdWr && busWrData == adc_pkg::OP_VOICE_ON))
    else $error("voice path opened without command");
  AST_VOICE_OFF: assert property ($fell(statOut.voiceEnable) |->
    $past(cmdWr && busWrData == adc_pkg::OP_VOICE_OFF))
    else $error("voice path closed without command");
  AST_EXT_ON: assert property ($rose(statOut.extEnable) |->
    $past(cmdWr && busWrData == adc_pkg::OP_EXT_ON))
    else $error("extension enabled without command");
  AST_EXT_OFF: assert property ($fell(statOut.extEnable) |->
    $past(cmdWr && busWrData == adc_pkg::OP_EXT_OFF))
    else $error("extension disabled without command");
  AST_GAIN_SRC: assert property ($changed(statOut.inputGain) |-> $past(cmdWr))
    else $error("gain moved without a byte");
  AST_GPO_SRC: assert property ($changed(statOut.gpoReg) |-> $past(cmdWr))
    else $error("power register moved without a byte");
  AST_RESUME: assert property (statOut.resumeReq |->
    $past(cmdWr && busWrData == adc_pkg::OP_RESUME))
    else $error("resume without command");
  AST_PAUSE: assert property ($rose(statOut.dmaPaused) |->
    $past(cmdWr && busWrData == adc_pkg::OP_PAUSE))
    else $error("pause without command");
  AST_CONT: assert property ($fell(statOut.dmaPaused) |->
    $past(dmaDone || cmdWr && busWrData == adc_pkg::OP_CONT))
    else $error("pause left without cause");
  COV_START: cover property (xferReq.start);
  COV_VOICE: cover property ($rose(statOut.voiceEnable));
  COV_PAUSE: cover property ($rose(statOut.dmaPaused));
endmodule : adc_command_set_props

// ==== dv/adc_dma_model.sv ====
// Far-side DMA engine model answering start requests
`timescale 1ns/1ps
module adc_dma_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Control
  input wire logic slow,
  input wire adc_pkg::adc_xfer_type xferReq,
  input wire adc_pkg::adc_stat_type statOut,
  output logic dmaDone
);
  logic active_q;
  logic [5:0] left_q;
  always_ff @(posedge ref_clk) begin
    dmaDone <= 1'b0;
    if (!rst_b) begin
      active_q <= 1'b0;
      left_q <= 6'h00;
    end else if (xferReq.start && xferReq.mode != adc_pkg::MODE_SILENCE) begin
      active_q <= 1'b1;
      left_q <= slow ? 6'h28 : 6'h02;
    end else if (active_q && !statOut.dmaPaused) begin
      left_q <= left_q - 6'h01;
      if (left_q == 6'h00) begin
        active_q <= 1'b0;
        dmaDone <= 1'b1;
      end
    end
  end
endmodule : adc_dma_model

// ==== dv/tb_adc_command_set.sv ====
// Top testbench for the command interpreter
`timescale 1ns/1ps
module tb_adc_command_set;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] busAddr = 2'h0;
  logic [7:0] busWrData = 8'h00;
  logic busWrite = 1'b0;
  logic busRead = 1'b0;
  logic [7:0] busRdData;
  logic dmaDone;
  logic slowDma = 1'b0;
  logic [7:0] rdVal;
  logic [7:0] base [7];
  adc_pkg::adc_xfer_type xferReq;
  adc_pkg::adc_xfer_type lastXfer;
  adc_pkg::adc_stat_type statOut;
  int numErrors = 0;
  int nTests = 0;
  int starts = 0;
  int dones = 0;
  int resumes = 0;
  int s;
  always #5 ref_clk = ~ref_clk;
  adc_command_set dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
    .busAddr(busAddr), .busWrData(busWrData), .busWrite(busWrite),
    .busRead(busRead), .busRdData(busRdData), .dmaDone(dmaDone),
    .xferReq(xferReq), .statOut(statOut));
  adc_dma_model dma_u (.ref_clk(ref_clk), .rst_b(rst_b), .slow(slowDma),
    .xferReq(xferReq), .statOut(statOut), .dmaDone(dmaDone));
  // Pulses tallied mid-cycle, where they stand settled
  always @(negedge ref_clk) begin
    if (xferReq.start === 1'b1) begin
      lastXfer = xferReq;
      starts++;
    end
    if (dmaDone === 1'b1) dones++;
    if (statOut.resumeReq === 1'b1) resumes++;
  end
  // ****
  // Access tasks
  // ****
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    busAddr <= a;
    busWrData <= d;
    busWrite <= 1'b1;
    @(posedge ref_clk);
    busWrite <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task automatic op(input logic [7:0] c);
    wr(adc_pkg::ADDR_CMD, c);
  endtask : op
  task automatic xfer(input logic [7:0] c, input logic [15:0] n);
    op(c);
    op(n[7:0]);
    op(n[15:8]);
  endtask : xfer
  task automatic rd(input logic [1:0] a);
    busAddr <= a;
    busRead <= 1'b1;
    @(posedge ref_clk);
    busRead <= 1'b0;
    @(negedge ref_clk);
    rdVal = busRdData;
    @(posedge ref_clk);
  endtask : rd
  task automatic check(input string nm, input logic [23:0] seen, exp);
    nTests++;
    if (seen !== exp) begin
      numErrors++;
      $display("Error %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic reset;
    rst_b <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
  endtask : reset
  task automatic results;
    if (numErrors == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  // Hang guard, far beyond the few hundred cycles used
  initial begin
    #200000;
    numErrors++;
    results();
  end
  initial begin
    base = '{adc_pkg::OP_CMP_LO, adc_pkg::OP_CMP_MD, adc_pkg::OP_CMP_HI,
      adc_pkg::OP_CMP_REC, adc_pkg::OP_AD4, adc_pkg::OP_AD26,
      adc_pkg::OP_AD2};
    reset();
    check("statOut", 24'(statOut), 24'h0);
    wr(adc_pkg::ADDR_STAT, adc_pkg::OP_EXT_ON);
    check("ext unmapped", statOut.extEnable, 1'b0);
    op(adc_pkg::OP_EXT_ON);
    check("ext on", statOut.extEnable, 1'b1);
    op(adc_pkg::OP_EXT_OFF);
    check("ext off", statOut.extEnable, 1'b0);
    op(adc_pkg::OP_EXT_ON);
    reset();
    check("ext reset", statOut.extEnable, 1'b0);
    s = starts;
    xfer(adc_pkg::OP_BLKSIZE, 16'h1234);
    check("size start", 24'(starts - s), 24'h0);
    for (int k = 0; k < 4; k++) begin
      op({4'h9, k[1], 2'b00, k[0]});
      check("fixed", lastXfer, {1'b1, 4'(k + 9), 1'b0, k[1], ~k[0],
        16'h1234});
    end
    for (int i = 0; i < 7; i++) begin
      for (int r = 0; r < 2; r++) begin
        xfer(base[i] | 8'(r), {4'h1, 4'(i), base[i]});
        check("coded", lastXfer, {1'b1, 4'(i + 1), r[0], i == 3, 1'b0,
          4'h1, 4'(i), base[i]});
      end
    end
    xfer(adc_pkg::OP_SILENCE, 16'h00ff);
    check("silence", {lastXfer.mode, lastXfer.count},
      {adc_pkg::MODE_SILENCE, 16'h00ff});
    op(adc_pkg::OP_ONE);
    rd(adc_pkg::ADDR_STAT);
    check("pending", rdVal, 8'h80);
    rd(adc_pkg::ADDR_CMD);
    check("one", rdVal, adc_pkg::READ_ONE);
    op(adc_pkg::OP_LEG_WR);
    op(adc_pkg::OP_VOICE_ON);
    check("swallow", statOut.voiceEnable, 1'b0);
    op(adc_pkg::OP_LEG_RD);
    op(adc_pkg::OP_ONE);
    rd(adc_pkg::ADDR_CMD);
    check("no reply", rdVal, adc_pkg::READ_ONE);
    op(adc_pkg::OP_VOICE_ON);
    check("voice on", statOut.voiceEnable, 1'b1);
    op(adc_pkg::OP_VOICE_ST);
    rd(adc_pkg::ADDR_CMD);
    check("voice st", rdVal, adc_pkg::ALL_ONES);
    op(adc_pkg::OP_VOICE_OFF);
    op(adc_pkg::OP_VOICE_ST);
    rd(adc_pkg::ADDR_CMD);
    check("voice st", {statOut.voiceEnable, rdVal}, 9'h0);
    op(adc_pkg::OP_GPO_WR);
    rd(adc_pkg::ADDR_STAT);
    check("collect", rdVal, 8'h01);
    op(8'ha5);
    op(adc_pkg::OP_GPO_RD);
    rd(adc_pkg::ADDR_CMD);
    check("gpo", {statOut.gpoReg, rdVal}, 16'ha5a5);
    op(adc_pkg::OP_GAIN_WR);
    op(8'h0f);
    op(adc_pkg::OP_GAIN_RD);
    rd(adc_pkg::ADDR_CMD);
    check("gain", {statOut.inputGain, rdVal}, 12'hf0f);
    rd(adc_pkg::ADDR_CTRL);
    check("gain port", rdVal, 8'h0f);
    s = resumes;
    op(adc_pkg::OP_RESUME);
    check("resume", 24'(resumes - s), 24'h1);
    slowDma <= 1'b1;
    s = dones;
    xfer(adc_pkg::OP_CMP_LO, 16'h0003);
    op(adc_pkg::OP_PAUSE);
    rd(adc_pkg::ADDR_DMA);
    check("paused", rdVal, 8'h13);
    repeat (60) @(posedge ref_clk);
    check("held", 24'(dones - s), 24'h0);
    op(adc_pkg::OP_CONT);
    check("cont", statOut.dmaPaused, 1'b0);
    repeat (60) @(posedge ref_clk);
    check("done", 24'(dones - s), 24'h1);
    results();
  end
endmodule : tb_adc_command_set
bind adc_command_set adc_command_set_props props_u (.ref_clk(ref_clk),
  .rst_b(rst_b), .busAddr(busAddr), .busWrData(busWrData),
  .busWrite(busWrite), .busRead(busRead), .busRdData(busRdData),
  .dmaDone(dmaDone), .xferReq(xferReq), .statOut(statOut));
